// ### core/dpasc_top.sv
`include "dpasc_cfg.svh"
`timescale 1ns/100ps

module dpasc_top (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// Serial link
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	input wire logic spi_cs_n,
	// Source selects and state selects
	input wire logic analog_source_select,
	input wire logic digital_source_select,
	input wire dpasc_pkg::dpasc_sel_t state_sel_path1,
	input wire dpasc_pkg::dpasc_sel_t state_sel_path2,
	// Parallel attenuation pins, bit 4 is the 16 dB step
	input wire dpasc_pkg::dpasc_atten_t parallel_bits_path1_i,
	output dpasc_pkg::dpasc_atten_t parallel_bits_path1_o,
	output logic parallel_bits_path1_oe_n,
	input wire dpasc_pkg::dpasc_atten_t parallel_bits_path2_i,
	output dpasc_pkg::dpasc_atten_t parallel_bits_path2_o,
	output logic parallel_bits_path2_oe_n,
	// Amplifier control
	input wire logic amp_powerdown_path1,
	input wire logic amp_powerdown_path2,
	input wire logic amp_bias_low_supply,
	output logic amp_enable_path1,
	output logic amp_enable_path2,
	output logic amp_bias_3v3,
	// Attenuator drive
	output dpasc_pkg::dpasc_atten_t atten_path1,
	output dpasc_pkg::dpasc_atten_t atten_path2,
	output dpasc_pkg::dpasc_dac_t dac_code_path1,
	output dpasc_pkg::dpasc_dac_t dac_code_path2,
	output logic dac_enable,
	output logic analog_ctrl_voltage_path1_oe_n,
	output logic analog_ctrl_voltage_path2_oe_n,
	// Status
	output logic frame_error
);
	import dpasc_pkg::*;

	logic [`DPASC_SYNC_W-1:0] pins_async;
	logic [`DPASC_SYNC_W-1:0] pins_s;
	logic cs_on_s;
	logic cs_s;
	logic sclk_s;
	logic sdi_s;
	logic aa_s;
	logic da_s;
	logic bias_s;
	logic pd_s [2];
	dpasc_sel_t sel_s [2];
	dpasc_atten_t par_s [2];

	// Select passes inverted, so a cleared synchroniser reads as deselected after reset
	assign pins_async = {!spi_cs_n, spi_sclk, spi_sdi, analog_source_select,
		digital_source_select, amp_bias_low_supply, amp_powerdown_path1,
		amp_powerdown_path2, state_sel_path1, state_sel_path2,
		parallel_bits_path1_i, parallel_bits_path2_i};

	dpasc_sync #(
		.WIDTH(`DPASC_SYNC_W)
	) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.din(pins_async),
		.dout(pins_s)
	);

	assign {cs_on_s, sclk_s, sdi_s, aa_s, da_s, bias_s, pd_s[0], pd_s[1],
		sel_s[0], sel_s[1], par_s[0], par_s[1]} = pins_s;
	assign cs_s = !cs_on_s;

	// Link side: shifter, bit counter, holding registers
	dpasc_state_t state_q;
	dpasc_state_t state_d;
	dpasc_frame_t sr_q;
	dpasc_frame_t sr_d;
	dpasc_frame_t hold_q;
	dpasc_frame_t hold_d;
	logic [`DPASC_CNT_W-1:0] cnt_q;
	logic [`DPASC_CNT_W-1:0] cnt_d;
	logic sclk_prev_q;
	logic sclk_prev_d;
	logic err_q;
	logic err_d;

	always_comb
	begin
		state_d = state_q;
		sr_d = sr_q;
		cnt_d = cnt_q;
		hold_d = hold_q;
		err_d = 1'b0;
		sclk_prev_d = sclk_s;
		case (state_q)
			DPASC_IDLE:
			begin
				cnt_d = `DPASC_CNT_RST;
				if (!cs_s)
					state_d = DPASC_SHIFT;
			end
			DPASC_SHIFT:
			begin
				if (cs_s)
				begin
					state_d = DPASC_IDLE;
					// Frames of the wrong length are dropped, not half applied
					if (cnt_q == `DPASC_FRAME_CNT)
						hold_d = sr_q;
					else
						err_d = 1'b1;
				end
				else if (sclk_s && !sclk_prev_q)
				begin
					sr_d = {sr_q[`DPASC_FRAME_BITS-2:0], sdi_s};
					if (cnt_q != `DPASC_CNT_MAX)
						cnt_d = cnt_q + `DPASC_CNT_ONE;
				end
			end
			default:
			begin
				state_d = DPASC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_q <= DPASC_IDLE;
			sr_q <= `DPASC_SR_RST;
			hold_q <= `DPASC_HOLD_RST;
			cnt_q <= `DPASC_CNT_RST;
			sclk_prev_q <= 1'b0;
			err_q <= 1'b0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			sr_q <= sr_d;
			hold_q <= hold_d;
			cnt_q <= cnt_d;
			sclk_prev_q <= sclk_prev_d;
			err_q <= err_d;
		end
	end

	assign frame_error = err_q;

	// Per-path attenuator drive
	dpasc_atten_t att_q [2];
	dpasc_dac_t dac_q [2];
	logic amp_en_q [2];

	for (genvar p = 0; p < 2; p++)
	begin : g_path
		localparam int BASE = p * `DPASC_PATH_BITS;
		dpasc_atten_t att_d;
		dpasc_atten_t att_serial;
		dpasc_dac_t dac_d;
		logic amp_en_d;

		// Select code n picks state n+1, with no new frame needed
		assign att_serial = hold_q[BASE + `DPASC_STATE_LSB
			+ `DPASC_ATT_W * int'(sel_s[p]) +: `DPASC_ATT_W];

		always_comb
		begin
			att_d = da_s ? att_serial : par_s[p];
			dac_d = hold_q[BASE + `DPASC_DAC_LSB +: `DPASC_DAC_W];
			amp_en_d = !pd_s[p];
		end

		always_ff @(posedge clock)
		begin
			if (!rst_n)
			begin
				att_q[p] <= `DPASC_ATT_RST;
				dac_q[p] <= `DPASC_DAC_RST;
				amp_en_q[p] <= 1'b0;
			end
			else if (ce)
			begin
				att_q[p] <= att_d;
				dac_q[p] <= dac_d;
				amp_en_q[p] <= amp_en_d;
			end
		end
	end

	// Shared mode flags
	logic da_q;
	logic da_d;
	logic aa_q;
	logic aa_d;
	logic bias_q;
	logic bias_d;

	always_comb
	begin
		da_d = da_s;
		aa_d = aa_s;
		bias_d = bias_s;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			da_q <= 1'b0;
			aa_q <= 1'b0;
			bias_q <= 1'b0;
		end
		else if (ce)
		begin
			da_q <= da_d;
			aa_q <= aa_d;
			bias_q <= bias_d;
		end
	end

	assign atten_path1 = att_q[0];
	assign atten_path2 = att_q[1];
	assign parallel_bits_path1_o = att_q[0];
	assign parallel_bits_path2_o = att_q[1];
	// Pins are only driven back in serial mode, never fighting the parallel source
	assign parallel_bits_path1_oe_n = !da_q;
	assign parallel_bits_path2_oe_n = !da_q;
	assign dac_code_path1 = dac_q[0];
	assign dac_code_path2 = dac_q[1];
	assign dac_enable = aa_q;
	assign analog_ctrl_voltage_path1_oe_n = !aa_q;
	assign analog_ctrl_voltage_path2_oe_n = !aa_q;
	assign amp_enable_path1 = amp_en_q[0];
	assign amp_enable_path2 = amp_en_q[1];
	// Bias level is owned by the system; only passed through
	assign amp_bias_3v3 = bias_q;

	// Checks
	logic [7:0] hold_dac1;
	logic [7:0] hold_dac2;
	logic [4:0] hold_p1s4;
	logic frame_end;
	assign hold_dac1 = hold_q[7:0];
	assign hold_dac2 = hold_q[35:28];
	assign hold_p1s4 = hold_q[27:23];
	assign frame_end = ce && state_q == DPASC_SHIFT && cs_s;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	property p_frame_len;
		frame_end && cnt_q != `DPASC_FRAME_CNT |=> $stable(hold_q) && frame_error;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("short frame applied");

	property p_shift_in;
		ce && !cs_s && state_q == DPASC_SHIFT && sclk_s && !sclk_prev_q
			|=> sr_q[0] == $past(sdi_s) && sr_q[55:1] == $past(sr_q[54:0]);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("bit not shifted in");

	property p_no_shift_idle;
		ce && cs_s |=> $stable(sr_q);
	endproperty
	a_no_shift_idle: assert property (p_no_shift_idle) else $error("shift while idle");

	property p_latch;
		frame_end && cnt_q == `DPASC_FRAME_CNT |=> hold_q == $past(sr_q);
	endproperty
	a_latch: assert property (p_latch) else $error("frame not latched");

	property p_hold_stable;
		ce && !cs_s |=> $stable(hold_q);
	endproperty
	a_hold_stable: assert property (p_hold_stable) else $error("hold changed in frame");

	property p_dac_map;
		ce |=> dac_code_path1 == $past(hold_dac1) && dac_code_path2 == $past(hold_dac2);
	endproperty
	a_dac_map: assert property (p_dac_map) else $error("DAC code mismatch");

	property p_state4;
		ce && da_s && sel_s[0] == 2'h3 |=> atten_path1 == $past(hold_p1s4) && !parallel_bits_path1_oe_n;
	endproperty
	a_state4: assert property (p_state4) else $error("state 4 not applied");

	property p_parallel;
		ce && !da_s |=> atten_path2 == $past(par_s[1]) && parallel_bits_path2_oe_n;
	endproperty
	a_parallel: assert property (p_parallel) else $error("parallel mode wrong");

	property p_amp;
		ce |=> amp_enable_path1 == !$past(pd_s[0]) && amp_enable_path2 == !$past(pd_s[1]);
	endproperty
	a_amp: assert property (p_amp) else $error("power-down not followed");

	property p_dac_src;
		ce |=> dac_enable == $past(aa_s) && analog_ctrl_voltage_path1_oe_n == !$past(aa_s);
	endproperty
	a_dac_src: assert property (p_dac_src) else $error("analog source wrong");

	c_frame_ok: cover property (frame_end && cnt_q == `DPASC_FRAME_CNT);
	c_frame_bad: cover property (frame_end && cnt_q != `DPASC_FRAME_CNT);
	c_state_hop: cover property (ce && da_s && sel_s[1] == 2'h3 ##1 ce && sel_s[1] == 2'h0);

endmodule

// ### core/dpasc_cfg.svh
`ifndef DPASC_CFG_SVH
`define DPASC_CFG_SVH

// Frame layout
`define DPASC_FRAME_BITS 56
`define DPASC_PATH_BITS 28
`define DPASC_DAC_LSB 0
`define DPASC_DAC_W 8
`define DPASC_STATE_LSB 8
`define DPASC_ATT_W 5
`define DPASC_NUM_STATES 4

// Bit counter
`define DPASC_CNT_W 6
`define DPASC_FRAME_CNT 6'h38
`define DPASC_CNT_MAX 6'h3F
`define DPASC_CNT_ONE 6'h01
`define DPASC_CNT_RST 6'h00

// Reset values
`define DPASC_HOLD_RST 56'h0
`define DPASC_SR_RST 56'h0
`define DPASC_ATT_RST 5'h00
`define DPASC_DAC_RST 8'h00

// Pins passed through the synchroniser
`define DPASC_SYNC_W 22

`endif

// ### core/dpasc_pkg.sv
`include "dpasc_cfg.svh"

package dpasc_pkg;

	typedef logic [`DPASC_ATT_W-1:0] dpasc_atten_t;
	typedef logic [`DPASC_DAC_W-1:0] dpasc_dac_t;
	typedef logic [1:0] dpasc_sel_t;
	typedef logic [`DPASC_FRAME_BITS-1:0] dpasc_frame_t;

	typedef enum logic [1:0] {
		DPASC_IDLE = 2'h1,
		DPASC_SHIFT = 2'h2
	} dpasc_state_t;

endpackage

// ### core/dpasc_sync.sv
`timescale 1ns/100ps

module dpasc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// Data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s1_d;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s2_d;

	// First stage feeds only the second stage
	always_comb
	begin
		s1_d = din;
		s2_d = s1_q;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s1_q <= '0;
			s2_q <= '0;
		end
		else if (ce)
		begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end

	assign dout = s2_q;

endmodule

// ### testbench/dpasc_spi_master.sv
`timescale 1ns/100ps

module dpasc_spi_master (
	// Serial link
	output logic spi_sclk,
	output logic spi_sdi,
	output logic spi_cs_n
);
	initial
	begin
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
		spi_cs_n = 1'b1;
	end

	// Sends the low n bits of f, bit n-1 first, rising edge mid-bit
	task automatic send(input dpasc_pkg::dpasc_frame_t f, input int n);
		spi_cs_n = 1'b0;
		#62.5;
		for (int i = n - 1; i >= 0; i--)
		begin
			spi_sdi = f[i];
			#62.5 spi_sclk = 1'b1;
			#62.5 spi_sclk = 1'b0;
		end
		#62.5 spi_cs_n = 1'b1;
		// Released data line must not keep showing the last bit
		spi_sdi = ~spi_sdi;
		#125;
	endtask
endmodule

// ### testbench/dual_path_attenuator_spi_control_test.sv
`timescale 1ns/100ps

module dual_path_attenuator_spi_control_test;
	import dpasc_pkg::*;
	logic clock = 1'b0;
	logic rst_n, ce, sclk, sdi, cs_n, asel, dsel, pd1, pd2, bias, oe1, oe2;
	logic en1, en2, b33, dac_en, av1, av2, ferr;
	dpasc_sel_t s1, s2;
	dpasc_atten_t pin1_drv, pin2_drv, pin1_o, pin2_o, pin1, pin2, at1, at2;
	dpasc_dac_t dc1, dc2;
	dpasc_atten_t st1[4], st2[4];
	dpasc_frame_t f;
	int fails, checks_done, cycles, err_pulses;

	// Two-way pins: device drives them while its enable is low
	assign pin1 = oe1 ? pin1_drv : pin1_o;
	assign pin2 = oe2 ? pin2_drv : pin2_o;

	dpasc_spi_master master (.spi_sclk(sclk), .spi_sdi(sdi), .spi_cs_n(cs_n));

	dpasc_top dut (.clock(clock), .rst_n(rst_n), .ce(ce), .spi_sclk(sclk), .spi_sdi(sdi),
		.spi_cs_n(cs_n), .analog_source_select(asel), .digital_source_select(dsel),
		.state_sel_path1(s1), .state_sel_path2(s2), .parallel_bits_path1_i(pin1),
		.parallel_bits_path1_o(pin1_o), .parallel_bits_path1_oe_n(oe1),
		.parallel_bits_path2_i(pin2), .parallel_bits_path2_o(pin2_o),
		.parallel_bits_path2_oe_n(oe2), .amp_powerdown_path1(pd1),
		.amp_powerdown_path2(pd2), .amp_bias_low_supply(bias), .amp_enable_path1(en1),
		.amp_enable_path2(en2), .amp_bias_3v3(b33), .atten_path1(at1), .atten_path2(at2),
		.dac_code_path1(dc1), .dac_code_path2(dc2), .dac_enable(dac_en),
		.analog_ctrl_voltage_path1_oe_n(av1), .analog_ctrl_voltage_path2_oe_n(av2),
		.frame_error(ferr));

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, and one-cycle error pulses counted as they pass
	always @(posedge clock)
	begin
		cycles++;
		if (ferr === 1'b1)
			err_pulses++;
		if (cycles == 60000)
		begin
			fails++;
			tally_and_finish();
		end
	end

	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		{asel, dsel, pd1, pd2, bias} = 5'h00;
		s1 = 2'h0;
		s2 = 2'h0;
		pin1_drv = 5'h00;
		pin2_drv = 5'h00;
		{fails, checks_done, cycles, err_pulses} = '0;
		wt(5);
		chk("reset oe", {oe1, oe2, av1, av2, en1, en2}, 16'h003C);
		chk("reset dac", {dc1, dc2}, 16'h0000);
		rst_n = 1'b1;
		wt(4);
		dsel = 1'b1;
		asel = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			st1[i] = 5'(3 + 7 * i);
			st2[i] = 5'(31 - 5 * i);
		end
		f = {st2[3], st2[2], st2[1], st2[0], 8'h3C, st1[3], st1[2], st1[1], st1[0], 8'hA5};
		master.send(f, 56);
		wt(6);
		chk("dac1", dc1, 16'h00A5);
		chk("dac2", dc2, 16'h003C);
		for (int k = 0; k < 4; k++)
		begin
			s1 = 2'(k);
			s2 = 2'(3 - k);
			wt(5);
			chk("atten1", at1, st1[k]);
			chk("atten2", at2, st2[3 - k]);
			chk("echo", {pin1, pin2}, {st1[k], st2[3 - k]});
		end
		chk("serial oe", {oe1, oe2}, 16'h0000);
		chk("dac on", {dac_en, av1, av2}, 16'h0004);
		fork
			master.send(~f, 56);
			begin
				wt(300);
				chk("hold mid", {dc1, at1}, {8'hA5, st1[3]});
			end
		join
		wt(6);
		chk("new dac1", dc1, 16'h005A);
		chk("state4 p1", at1, 5'(~st1[3]));
		chk("state1 p2", at2, 5'(~st2[0]));
		master.send(f, 55);
		wt(6);
		chk("err pulses", 16'(err_pulses), 16'h0001);
		chk("kept dac1", dc1, 16'h005A);
		dsel = 1'b0;
		asel = 1'b0;
		// The echoed code is still in the pin synchroniser when the pins are released
		wt(5);
		for (int k = 0; k < 6; k++)
		begin
			pin1_drv = 5'(1 << k);
			pin2_drv = 5'(31 >> k);
			wt(5);
			chk("par1", at1, pin1_drv);
			chk("par2", at2, pin2_drv);
		end
		chk("par oe", {oe1, oe2}, 16'h0003);
		chk("dac off", {dac_en, av1, av2}, 16'h0003);
		for (int k = 0; k < 8; k++)
		begin
			{bias, pd2, pd1} = 3'(k);
			wt(5);
			chk("amp", {en1, en2, b33}, {~pd1, ~pd2, bias});
		end
		ce = 1'b0;
		{bias, pd2, pd1} = 3'h0;
		wt(5);
		chk("frozen", {en1, en2, b33}, 16'h0001);
		ce = 1'b1;
		wt(5);
		chk("thawed", {en1, en2, b33}, 16'h0006);
		tally_and_finish();
	end
endmodule
